// *** core/csi_core.sv ***
`timescale 1ns/1ps
`include "csi_params.svh"
module csi_core #(
  parameter int N_IRQ = 8,
  parameter logic [N_IRQ-1:0] LEVEL_MASK = 8'hC0,
  parameter int PC_W = 13,
  parameter logic [15:0] TOP_OF_RAM = `CSI_TOP_OF_RAM,
  parameter logic [PC_W-1:0] BOOT_START = `CSI_BOOT_START
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  output logic op_ready,
  input wire csi_pkg::csi_op_t op,
  input wire csi_pkg::csi_alu_t alu_fn,
  input wire logic [4:0] rd,
  input wire logic [4:0] rr,
  input wire logic imm_sel,
  input wire logic [7:0] imm,
  input wire csi_pkg::csi_ptr_t ptr_sel,
  input wire csi_pkg::csi_mode_t ptr_mode,
  input wire logic [5:0] disp,
  input wire logic [PC_W-1:0] target,
  output logic [PC_W-1:0] pc_q,
  output logic [15:0] mem_addr_q,
  output logic [7:0] mem_wdata_q,
  output logic mem_we_q,
  output logic mem_re_q,
  input wire logic [7:0] mem_rdata,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_q,
  input wire logic [N_IRQ-1:0] irq_event,
  input wire logic [N_IRQ-1:0] irq_level,
  input wire logic sleep_req,
  input wire logic boot_reset_fuse,
  input wire logic app_section_lock_bit,
  input wire logic boot_section_lock_bit,
  output logic [7:0] status_register_q,
  output logic irq_taken_q,
  output logic [PC_W-1:0] irq_vector_q
);
  import csi_pkg::*;
  localparam int IW = (N_IRQ > 1) ? $clog2(N_IRQ) : 1;

  csi_state_t state_q;
  logic [1:0] cyc_q;
  logic [7:0] rf_q [32];
  logic [15:0] sp_q;
  logic [7:0] cpu_control_register_q;
  logic [N_IRQ-1:0] irq_en_q;
  logic [N_IRQ-1:0] irq_flag_q;
  logic inhibit_q;
  logic is_irq_q;
  logic is_return_from_handler_q;
  logic [15:0] ret_addr_q;
  logic [PC_W-1:0] jump_q;
  logic [4:0] load_dst_q;
  logic [IW-1:0] win_q;

  logic accept;
  logic take;
  logic blocked;
  logic irq_any;
  logic [IW-1:0] irq_idx;
  logic [N_IRQ-1:0] pend;
  logic [N_IRQ-1:0] src_state;
  logic [4:0] ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] ptr_addr;
  logic [15:0] ptr_next;
  logic [7:0] opa;
  logic [7:0] opb;
  logic [8:0] sum;
  logic [7:0] res;
  logic [5:0] flags;
  logic [PC_W-1:0] vec_base;
  logic [PC_W-1:0] pc_inc;
  logic in_boot;

  genvar g;
  generate
    for (g = 0; g < N_IRQ; g++)
    begin : g_src
      // Level sources bypass the flag and vanish with their condition.
      if (LEVEL_MASK[g])
      begin : g_lvl
        assign src_state[g] = irq_level[g];
      end
      else
      begin : g_flg
        assign src_state[g] = irq_flag_q[g];
      end
    end
  endgenerate

  assign pend = src_state & irq_en_q;

  csi_irq_arb #(
    .N(N_IRQ),
    .IW(IW)
  ) u_arb (
    .req(pend),
    .any(irq_any),
    .idx(irq_idx)
  );

  assign in_boot = (pc_q >= BOOT_START);
  // A lock bit blocks interrupts whose vectors lie in the other section.
  assign blocked = (boot_section_lock_bit && in_boot && !cpu_control_register_q[`CSI_CTRL_RELOC])
                || (app_section_lock_bit && !in_boot && cpu_control_register_q[`CSI_CTRL_RELOC]);
  assign take = (state_q == CSI_ST_RUN) && status_register_q[`CSI_STATUS_REGISTER_I] && irq_any
             && !inhibit_q && !blocked
             && !(op_valid && (op == CSI_OP_CLI));
  assign op_ready = (state_q == CSI_ST_RUN) && !take && !sleep_req;
  assign accept = op_ready && op_valid;
  assign vec_base = cpu_control_register_q[`CSI_CTRL_RELOC] ? BOOT_START : '0;
  assign pc_inc = pc_q + PC_W'(1);

  always_comb
  begin
    case (ptr_sel)
      CSI_PTR_X: ptr_lo = `CSI_REG_XL;
      CSI_PTR_Y: ptr_lo = `CSI_REG_YL;
      default: ptr_lo = `CSI_REG_ZL;
    endcase
  end
  assign ptr_val = {rf_q[ptr_lo + 5'h01], rf_q[ptr_lo]};
  always_comb
  begin
    ptr_addr = ptr_val;
    ptr_next = ptr_val;
    case (ptr_mode)
      CSI_AM_DISP: ptr_addr = ptr_val + {10'h000, disp};
      CSI_AM_POSTINC: ptr_next = ptr_val + 16'h0001;
      default:
      begin
        ptr_addr = ptr_val - 16'h0001;
        ptr_next = ptr_addr;
      end
    endcase
  end

  assign opa = rf_q[rd];
  assign opb = imm_sel ? imm : rf_q[rr];
  always_comb
  begin
    sum = 9'h000;
    res = opb;
    flags = status_register_q[5:0];
    case (alu_fn)
      CSI_ALU_ADD:
      begin
        sum = {1'b0, opa} + {1'b0, opb};
        res = sum[7:0];
        flags[`CSI_STATUS_REGISTER_C] = sum[8];
        flags[`CSI_STATUS_REGISTER_H] = ({1'b0, opa[3:0]} + {1'b0, opb[3:0]}) > 5'h0F;
        flags[`CSI_STATUS_REGISTER_V] = (opa[7] == opb[7]) && (res[7] != opa[7]);
      end
      CSI_ALU_SUB:
      begin
        sum = {1'b0, opa} - {1'b0, opb};
        res = sum[7:0];
        flags[`CSI_STATUS_REGISTER_C] = sum[8];
        flags[`CSI_STATUS_REGISTER_H] = opb[3:0] > opa[3:0];
        flags[`CSI_STATUS_REGISTER_V] = (opa[7] != opb[7]) && (res[7] != opa[7]);
      end
      CSI_ALU_AND:
      begin
        res = opa & opb;
        flags[`CSI_STATUS_REGISTER_V] = 1'b0;
      end
      CSI_ALU_OR:
      begin
        res = opa | opb;
        flags[`CSI_STATUS_REGISTER_V] = 1'b0;
      end
      CSI_ALU_XOR:
      begin
        res = opa ^ opb;
        flags[`CSI_STATUS_REGISTER_V] = 1'b0;
      end
      default: res = opb;
    endcase
    if (alu_fn != CSI_ALU_MOV)
    begin
      flags[`CSI_STATUS_REGISTER_N] = res[7];
      flags[`CSI_STATUS_REGISTER_Z] = (res == 8'h00);
      flags[`CSI_STATUS_REGISTER_S] = res[7] ^ flags[`CSI_STATUS_REGISTER_V];
    end
  end

  // Sequencer: boot vector pick, loads, wake delay, entry and return.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= CSI_ST_BOOT;
      cyc_q <= 2'h0;
      pc_q <= '0;
      is_irq_q <= 1'b0;
      is_return_from_handler_q <= 1'b0;
      ret_addr_q <= 16'h0000;
      jump_q <= '0;
      load_dst_q <= 5'h00;
      win_q <= '0;
    end
    else
    begin
      case (state_q)
        CSI_ST_BOOT:
        begin
          pc_q <= boot_reset_fuse ? BOOT_START : '0;
          state_q <= CSI_ST_RUN;
        end
        CSI_ST_RUN:
        begin
          cyc_q <= 2'h0;
          if (take)
          begin
            win_q <= irq_idx;
            is_irq_q <= 1'b1;
            ret_addr_q <= 16'(pc_q);
            jump_q <= vec_base + PC_W'((32'(irq_idx) + 1) * `CSI_VEC_STEP);
            state_q <= sleep_req ? CSI_ST_WAKE : CSI_ST_ENTRY;
          end
          else if (accept)
          begin
            pc_q <= pc_inc;
            case (op)
              CSI_OP_LD, CSI_OP_POP:
              begin
                load_dst_q <= rd;
                state_q <= CSI_ST_LOAD;
              end
              CSI_OP_JMP: pc_q <= target;
              CSI_OP_CALL:
              begin
                is_irq_q <= 1'b0;
                ret_addr_q <= 16'(pc_inc);
                jump_q <= target;
                state_q <= CSI_ST_ENTRY;
              end
              CSI_OP_RET, CSI_OP_RETURN_FROM_HANDLER:
              begin
                is_return_from_handler_q <= (op == CSI_OP_RETURN_FROM_HANDLER);
                state_q <= CSI_ST_RETURN;
              end
              default: state_q <= CSI_ST_RUN;
            endcase
          end
        end
        CSI_ST_LOAD: state_q <= CSI_ST_RUN;
        CSI_ST_WAKE:
        begin
          cyc_q <= cyc_q + 2'h1;
          if (cyc_q == 2'(`CSI_WAKE_CYC - 1))
          begin
            cyc_q <= 2'h0;
            state_q <= CSI_ST_ENTRY;
          end
        end
        CSI_ST_ENTRY:
        begin
          cyc_q <= cyc_q + 2'h1;
          if (cyc_q == 2'(`CSI_ENTRY_CYC - 1))
          begin
            pc_q <= jump_q;
            state_q <= CSI_ST_RUN;
          end
        end
        CSI_ST_RETURN:
        begin
          cyc_q <= cyc_q + 2'h1;
          if (cyc_q == 2'h1)
          begin
            ret_addr_q[15:8] <= mem_rdata;
          end
          if (cyc_q == 2'h2)
          begin
            ret_addr_q[7:0] <= mem_rdata;
          end
          if (cyc_q == 2'(`CSI_RETURN_CYC - 1))
          begin
            pc_q <= ret_addr_q[PC_W-1:0];
            state_q <= CSI_ST_RUN;
          end
        end
        default: state_q <= CSI_ST_RUN;
      endcase
    end
  end

  // Stack pointer and the memory strobes that go with it.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sp_q <= TOP_OF_RAM;
      mem_addr_q <= 16'h0000;
      mem_wdata_q <= 8'h00;
      mem_we_q <= 1'b0;
      mem_re_q <= 1'b0;
    end
    else
    begin
      mem_we_q <= 1'b0;
      mem_re_q <= 1'b0;
      if (io_we && (io_addr == `CSI_IO_SP_LOW))
      begin
        sp_q[7:0] <= io_wdata;
      end
      if (io_we && (io_addr == `CSI_IO_SP_HIGH))
      begin
        sp_q[15:8] <= io_wdata;
      end
      if (accept)
      begin
        case (op)
          CSI_OP_PUSH:
          begin
            mem_addr_q <= sp_q;
            mem_wdata_q <= opa;
            mem_we_q <= 1'b1;
            sp_q <= sp_q - 16'h0001;
          end
          CSI_OP_POP:
          begin
            mem_addr_q <= sp_q + 16'h0001;
            mem_re_q <= 1'b1;
            sp_q <= sp_q + 16'h0001;
          end
          CSI_OP_LD:
          begin
            mem_addr_q <= ptr_addr;
            mem_re_q <= 1'b1;
          end
          CSI_OP_ST:
          begin
            mem_addr_q <= ptr_addr;
            mem_wdata_q <= opa;
            mem_we_q <= 1'b1;
          end
          default: mem_we_q <= 1'b0;
        endcase
      end
      if ((state_q == CSI_ST_ENTRY) && (cyc_q < 2'h2))
      begin
        mem_addr_q <= sp_q;
        mem_wdata_q <= (cyc_q == 2'h0) ? ret_addr_q[7:0] : ret_addr_q[15:8];
        mem_we_q <= 1'b1;
        sp_q <= sp_q - 16'h0001;
      end
      if ((state_q == CSI_ST_RETURN) && (cyc_q < 2'h2))
      begin
        mem_addr_q <= sp_q + 16'h0001;
        mem_re_q <= 1'b1;
        sp_q <= sp_q + 16'h0001;
      end
    end
  end

  // Register file: ALU write-back, load results and pointer updates.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int k = 0; k < 32; k++)
      begin
        rf_q[k] <= 8'h00;
      end
    end
    else
    begin
      if (accept && ((op == CSI_OP_LD) || (op == CSI_OP_ST)) && (ptr_mode != CSI_AM_DISP))
      begin
        rf_q[ptr_lo] <= ptr_next[7:0];
        rf_q[ptr_lo + 5'h01] <= ptr_next[15:8];
      end
      if (accept && (op == CSI_OP_ALU))
      begin
        rf_q[rd] <= res;
      end
      if (state_q == CSI_ST_LOAD)
      begin
        rf_q[load_dst_q] <= mem_rdata;
      end
    end
  end

  // Status register; nothing here saves or restores it around a handler.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_register_q <= 8'h00;
      inhibit_q <= 1'b0;
    end
    else
    begin
      if (io_we && (io_addr == `CSI_IO_STATUS))
      begin
        status_register_q <= io_wdata;
      end
      if (accept)
      begin
        inhibit_q <= (op == CSI_OP_SEI);
        case (op)
          CSI_OP_ALU: status_register_q[5:0] <= flags;
          CSI_OP_SEI: status_register_q[`CSI_STATUS_REGISTER_I] <= 1'b1;
          CSI_OP_CLI: status_register_q[`CSI_STATUS_REGISTER_I] <= 1'b0;
          default: inhibit_q <= 1'b0;
        endcase
      end
      if (take)
      begin
        status_register_q[`CSI_STATUS_REGISTER_I] <= 1'b0;
      end
      if ((state_q == CSI_ST_RETURN) && (cyc_q == 2'(`CSI_RETURN_CYC - 1)) && is_return_from_handler_q)
      begin
        status_register_q[`CSI_STATUS_REGISTER_I] <= 1'b1;
        inhibit_q <= 1'b1;
      end
    end
  end

  // Flags: a new event beats both software and hardware clears.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_flag_q <= '0;
      irq_en_q <= '0;
      cpu_control_register_q <= 8'h00;
      irq_taken_q <= 1'b0;
      irq_vector_q <= '0;
    end
    else
    begin
      irq_taken_q <= take;
      if (take)
      begin
        irq_vector_q <= vec_base + PC_W'((32'(irq_idx) + 1) * `CSI_VEC_STEP);
      end
      if (io_we && (io_addr == `CSI_IO_IRQ_EN))
      begin
        irq_en_q <= io_wdata[N_IRQ-1:0];
      end
      if (io_we && (io_addr == `CSI_IO_CPU_CTRL))
      begin
        cpu_control_register_q <= io_wdata;
      end
      for (int k = 0; k < N_IRQ; k++)
      begin
        if (irq_event[k] && !LEVEL_MASK[k])
        begin
          irq_flag_q[k] <= 1'b1;
        end
        else if (io_we && (io_addr == `CSI_IO_IRQ_FLAG) && io_wdata[k])
        begin
          irq_flag_q[k] <= 1'b0;
        end
        else if (take && (irq_idx == IW'(k)))
        begin
          irq_flag_q[k] <= 1'b0;
        end
      end
    end
  end

  // I/O read port, answered one cycle after the strobe.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_rdata_q <= 8'h00;
    end
    else if (io_re)
    begin
      if (io_addr == `CSI_IO_SP_LOW)
        io_rdata_q <= sp_q[7:0];
      else if (io_addr == `CSI_IO_SP_HIGH)
        io_rdata_q <= sp_q[15:8];
      else if (io_addr == `CSI_IO_STATUS)
        io_rdata_q <= status_register_q;
      else if (io_addr == `CSI_IO_CPU_CTRL)
        io_rdata_q <= cpu_control_register_q;
      else if (io_addr == `CSI_IO_IRQ_EN)
        io_rdata_q <= 8'(irq_en_q);
      else if (io_addr == `CSI_IO_IRQ_FLAG)
        io_rdata_q <= 8'(src_state);
      else
        io_rdata_q <= 8'h00;
    end
  end
endmodule : csi_core

// *** core/csi_params.svh ***
// What this block does
// - Top six working registers form three 16-bit pointers, low byte then high byte.
// - Pointer accesses use fixed displacement, post-increment or pre-decrement.
// - Stack pointer addresses the stack top; the stack grows downward.
// - Byte push lowers the stack pointer by one; call or entry by two.
// - Byte pop raises the stack pointer by one; return by two.
// - Stack pointer is two read-write I/O bytes reset to top of RAM.
// - Core runs on the undivided clock, one instruction accepted per cycle.
// - One cycle reads two operands, runs the ALU and writes the result.
// - A source is taken only when its enable and the global enable are set.
// - Programmed lock bits block interrupts depending on the program counter.
// - Vectors sit at low addresses; lower address means higher priority.
// - Vector select relocates interrupt vectors; boot fuse relocates the reset vector.
// - Taking an interrupt clears the global enable until software or return sets it.
// - Taking a flag source vectors to it and clears its flag.
// - Writing one to a flag position clears it; zero leaves it.
// - Flags stay latched while disabled and are then served by priority.
// - Level sources request only while their condition is present.
// - After a handler return one main instruction runs before any interrupt.
// - The status register is not saved or restored on entry or return.
// - Global disable acts at once, even against a same-cycle request.
// - After global enable the next instruction runs before any interrupt.
// - Global enable is status bit 7, reset zero, set and cleared by instructions.
// - Entry takes four cycles pushing the counter; sleep wake adds four.
// - Handler return takes four cycles, pops two bytes, sets global enable.
`ifndef CSI_PARAMS_SVH
`define CSI_PARAMS_SVH
`define CSI_IO_CPU_CTRL 6'h35
`define CSI_IO_IRQ_EN 6'h10
`define CSI_IO_IRQ_FLAG 6'h11
`define CSI_IO_SP_LOW 6'h3D
`define CSI_IO_SP_HIGH 6'h3E
`define CSI_IO_STATUS 6'h3F
`define CSI_STATUS_REGISTER_I 7
`define CSI_STATUS_REGISTER_H 5
`define CSI_STATUS_REGISTER_S 4
`define CSI_STATUS_REGISTER_V 3
`define CSI_STATUS_REGISTER_N 2
`define CSI_STATUS_REGISTER_Z 1
`define CSI_STATUS_REGISTER_C 0
`define CSI_CTRL_RELOC 0
`define CSI_TOP_OF_RAM 16'h04FF
`define CSI_BOOT_START 13'h1C00
`define CSI_VEC_STEP 2
`define CSI_ENTRY_CYC 4
`define CSI_RETURN_CYC 4
`define CSI_WAKE_CYC 4
`define CSI_REG_XL 5'h1A
`define CSI_REG_YL 5'h1C
`define CSI_REG_ZL 5'h1E
`endif

// *** core/csi_pkg.sv ***
package csi_pkg;
  typedef enum logic [3:0] {
    CSI_OP_NOP, CSI_OP_ALU, CSI_OP_LD, CSI_OP_ST, CSI_OP_PUSH, CSI_OP_POP,
    CSI_OP_CALL, CSI_OP_JMP, CSI_OP_RET, CSI_OP_RETURN_FROM_HANDLER, CSI_OP_SEI, CSI_OP_CLI
  } csi_op_t;
  typedef enum logic [2:0] {
    CSI_ALU_ADD, CSI_ALU_SUB, CSI_ALU_AND, CSI_ALU_OR, CSI_ALU_XOR, CSI_ALU_MOV
  } csi_alu_t;
  typedef enum logic [1:0] {CSI_PTR_X, CSI_PTR_Y, CSI_PTR_Z} csi_ptr_t;
  typedef enum logic [1:0] {CSI_AM_DISP, CSI_AM_POSTINC, CSI_AM_PREDEC} csi_mode_t;
  typedef enum logic [2:0] {
    CSI_ST_BOOT, CSI_ST_RUN, CSI_ST_LOAD, CSI_ST_WAKE, CSI_ST_ENTRY, CSI_ST_RETURN
  } csi_state_t;
endpackage : csi_pkg

// *** core/csi_irq_arb.sv ***
`timescale 1ns/1ps
module csi_irq_arb #(
  parameter int N = 8,
  parameter int IW = 3
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [IW-1:0] idx
);
  logic [N-1:0] first;
  logic [N:0] seen;
  assign seen[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_chain
      // Lowest index wins, matching the lowest vector address.
      assign first[i] = req[i] & ~seen[i];
      assign seen[i+1] = seen[i] | req[i];
    end
  endgenerate
  assign any = seen[N];
  always_comb
  begin
    idx = '0;
    for (int k = 0; k < N; k++)
    begin
      if (first[k])
      begin
        idx = IW'(k);
      end
    end
  end
endmodule : csi_irq_arb

// *** test/csi_assertions.sv ***
`timescale 1ns/1ps
module csi_assertions #(
  parameter int PC_W = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire csi_pkg::csi_op_t op,
  input wire logic sleep_req,
  input wire logic [PC_W-1:0] pc_q,
  input wire logic [15:0] mem_addr_q,
  input wire logic mem_we_q,
  input wire logic io_re,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_rdata_q,
  input wire logic [7:0] status_register_q,
  input wire logic irq_taken_q,
  input wire logic [PC_W-1:0] irq_vector_q
);
  import csi_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_take_needs_gie: assert property ($rose(irq_taken_q)
    |-> $past(status_register_q[7]))
    else $error("interrupt taken while global enable was clear");
  a_take_clears_gie: assert property (irq_taken_q |-> !status_register_q[7])
    else $error("global enable still set after interrupt entry");
  a_take_single: assert property (irq_taken_q |=> !irq_taken_q)
    else $error("second interrupt accepted right after the first");
  a_entry_stall: assert property (irq_taken_q |-> !op_ready [*4])
    else $error("instruction accepted during interrupt entry");
  a_entry_push: assert property (irq_taken_q && !$past(sleep_req)
    |-> ##1 mem_we_q ##1 (mem_we_q && mem_addr_q == $past(mem_addr_q) - 16'h0001))
    else $error("entry did not push two bytes downward");
  a_vector_load: assert property (irq_taken_q && !$past(sleep_req)
    |-> ##4 pc_q == irq_vector_q)
    else $error("vector not reached four cycles after entry");
  a_wake_delay: assert property (irq_taken_q && $past(sleep_req)
    |-> ##8 pc_q == irq_vector_q)
    else $error("vector not reached eight cycles after wake entry");
  a_status_read: assert property (io_re && io_addr == 6'h3F
    |=> io_rdata_q == $past(status_register_q))
    else $error("status read returned a wrong value");
  a_cli_blocks: assert property (op_valid && op_ready && op == CSI_OP_CLI
    |=> !status_register_q[7] && !irq_taken_q)
    else $error("interrupt or enable survived the disable instruction");
  a_sei_delay: assert property (op_valid && op_ready && op == CSI_OP_SEI
    |=> status_register_q[7] ##1 !irq_taken_q)
    else $error("interrupt taken right after the enable instruction");
  c_take: cover property (irq_taken_q && !$past(sleep_req));
  c_wake: cover property (irq_taken_q && $past(sleep_req));
  c_sei: cover property (op_valid && op_ready && op == CSI_OP_SEI);
endmodule : csi_assertions

bind csi_core csi_assertions #(.PC_W(PC_W)) csi_assertions_inst (.clk, .rst_n, .op_valid, .op_ready,
  .op, .sleep_req, .pc_q, .mem_addr_q, .mem_we_q, .io_re, .io_addr, .io_rdata_q,
  .status_register_q, .irq_taken_q, .irq_vector_q);

// *** test/csi_mem_model.sv ***
`timescale 1ns/1ps
module csi_mem_model (
  input wire logic clk,
  input wire logic [15:0] mem_addr_q,
  input wire logic [7:0] mem_wdata_q,
  input wire logic mem_we_q,
  input wire logic mem_re_q,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:65535];
  // Read data follows the address while the strobe is high and shows the inverse otherwise.
  assign mem_rdata = (mem_re_q === 1'b1) ? ram[mem_addr_q] : ~ram[mem_addr_q];
  always @(posedge clk)
  begin
    if (mem_we_q === 1'b1)
      ram[mem_addr_q] <= mem_wdata_q;
  end
endmodule : csi_mem_model

// *** test/cpu_stack_and_interrupt_entry_test.sv ***
`timescale 1ns/1ps
module cpu_stack_and_interrupt_entry_test;
  import csi_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, op_ready, mem_we_q, mem_re_q;
  logic io_we = 1'b0, io_re = 1'b0, sleep_req = 1'b0, irq_taken_q, app_lk = 1'b0;
  csi_op_t op = CSI_OP_NOP;
  csi_alu_t alu_fn = CSI_ALU_MOV;
  csi_ptr_t ptr_sel = CSI_PTR_X;
  csi_mode_t ptr_mode = CSI_AM_DISP;
  logic [4:0] rd = '0;
  logic [5:0] disp = '0, io_addr = '0;
  logic [7:0] imm = '0, io_wdata = '0, irq_event = '0, irq_level = '0;
  logic [7:0] mem_wdata_q, mem_rdata, io_rdata_q, status_register_q, rv, wd, a, pushed [6];
  logic [12:0] target = '0, pc_q, irq_vector_q, pc0;
  logic [15:0] mem_addr_q, sp, wa, ra, v16;
  logic [31:0] rnd = 32'h2D62;
  int error_cnt = 0, checks_done = 0, takes = 0, tk = 0;
  csi_mode_t pm [4] = '{CSI_AM_POSTINC, CSI_AM_POSTINC, CSI_AM_PREDEC, CSI_AM_DISP};
  logic [15:0] po [4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0001};

  always #2 clk = ~clk;

  csi_core csi_core_inst (.clk, .rst_n, .op_valid, .op_ready, .op, .alu_fn, .rd, .rr(5'd0),
    .imm_sel(1'b1), .imm, .ptr_sel, .ptr_mode, .disp, .target, .pc_q, .mem_addr_q, .mem_wdata_q,
    .mem_we_q, .mem_re_q, .mem_rdata, .io_we, .io_re, .io_addr, .io_wdata, .io_rdata_q,
    .irq_event, .irq_level, .sleep_req, .boot_reset_fuse(1'b0), .app_section_lock_bit(app_lk),
    .boot_section_lock_bit(1'b0), .status_register_q, .irq_taken_q, .irq_vector_q);
  csi_mem_model csi_mem_model_inst (.clk, .mem_addr_q, .mem_wdata_q, .mem_we_q, .mem_re_q,
    .mem_rdata);

  always @(posedge clk)
  begin
    if (mem_we_q === 1'b1)
      {wa, wd} <= {mem_addr_q, mem_wdata_q};
    if (mem_re_q === 1'b1)
      ra <= mem_addr_q;
    if (irq_taken_q === 1'b1)
      takes <= takes + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [12:0] vec(input logic [12:0] base, input int idx);
    return base + 13'(2 * (idx + 1));
  endfunction : vec

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic wait_hi(input string what, ref logic sig);
    int n = 0;
    while (sig !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 200)
      begin
        chk(what, 16'h0000, 16'h0001);
        end_sim();
      end
    end
  endtask : wait_hi

  task automatic run(input csi_op_t o, input logic [4:0] r, input logic [7:0] v);
    @(posedge clk);
    #1;
    {op, rd, imm, op_valid} = {o, r, v, 1'b1};
    wait_hi("op_ready", op_ready);
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    tk = takes;
    wait_hi("op_done", op_ready);
  endtask : run

  task automatic io_acc(input logic wr, input logic [5:0] ad, input logic [7:0] d);
    @(posedge clk);
    #1;
    {io_addr, io_wdata, io_we, io_re} = {ad, d, wr, !wr};
    @(posedge clk);
    #1;
    {io_we, io_re} = 2'b00;
    rv = io_rdata_q;
  endtask : io_acc

  task automatic read_sp;
    io_acc(1'b0, 6'h3D, 8'h00);
    v16[7:0] = rv;
    io_acc(1'b0, 6'h3E, 8'h00);
    v16[15:8] = rv;
  endtask : read_sp

  task automatic fire(input logic [7:0] m);
    @(posedge clk);
    #1;
    irq_event = m;
    @(posedge clk);
    #1;
    irq_event = 8'h00;
  endtask : fire

  task automatic serve(input int idx, input logic [12:0] base);
    int t0 = takes;
    run(CSI_OP_NOP, 5'd0, 8'h00);
    chk("early_take", 16'(tk), 16'(t0));
    chk("taken", 16'(takes), 16'(t0 + 1));
    chk("vector", 16'(pc_q), 16'(vec(base, idx)));
    chk("gie_clear", 16'(status_register_q[7]), 16'h0000);
    irq_level = 8'h00;
    sp = sp - 16'h0002;
    read_sp();
    chk("sp_entry", v16, sp);
    run(CSI_OP_RETURN_FROM_HANDLER, 5'd0, 8'h00);
    sp = sp + 16'h0002;
    read_sp();
    chk("sp_return", v16, sp);
    chk("gie_set", 16'(status_register_q[7]), 16'h0001);
  endtask : serve

  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    io_acc(1'b0, 6'h3D, 8'h00);
    chk("sp_low_rst", 16'(rv), 16'h00FF);
    io_acc(1'b0, 6'h3E, 8'h00);
    chk("sp_high_rst", 16'(rv), 16'h0004);
    io_acc(1'b0, 6'h3F, 8'h00);
    chk("status_rst", 16'(rv), 16'h0000);
    io_acc(1'b0, 6'h20, 8'h00);
    chk("unmapped", 16'(rv), 16'h0000);
    sp = 16'h04F0;
    io_acc(1'b1, 6'h3D, 8'hF0);
    io_acc(1'b1, 6'h3E, 8'h04);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      a = rnd[7:0] + rnd[15:8];
      pushed[i] = a;
      alu_fn = CSI_ALU_MOV;
      run(CSI_OP_ALU, 5'(16 + i), rnd[7:0]);
      alu_fn = CSI_ALU_ADD;
      run(CSI_OP_ALU, 5'(16 + i), rnd[15:8]);
      run(CSI_OP_PUSH, 5'(16 + i), 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk("push_data", 16'(wd), 16'(a));
      chk("push_addr", wa, sp);
      sp = sp - 16'h0001;
    end
    read_sp();
    chk("sp_pushed", v16, sp);
    for (int i = 0; i < 6; i++)
    begin
      run(CSI_OP_POP, 5'd8, 8'h00);
      sp = sp + 16'h0001;
      chk("pop_addr", ra, sp);
    end
    run(CSI_OP_PUSH, 5'd8, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("pop_data", 16'(wd), 16'(pushed[0]));
    sp = sp - 16'h0001;
    $display("test stack done");
    for (int p = 0; p < 3; p++)
    begin
      rnd = lfsr(rnd);
      v16 = {8'h01, rnd[7:0]};
      disp = rnd[13:8];
      alu_fn = CSI_ALU_MOV;
      run(CSI_OP_ALU, 5'(26 + 2 * p), v16[7:0]);
      run(CSI_OP_ALU, 5'(27 + 2 * p), v16[15:8]);
      ptr_sel = csi_ptr_t'(p);
      for (int m = 0; m < 4; m++)
      begin
        ptr_mode = pm[m];
        run(CSI_OP_ST, 5'd16, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk("ptr_addr", wa, v16 + po[m] + (m == 3 ? 16'(disp) : 16'h0000));
      end
    end
    pc0 = pc_q;
    rnd = lfsr(rnd);
    target = rnd[12:0];
    run(CSI_OP_CALL, 5'd0, 8'h00);
    chk("call_pc", 16'(pc_q), 16'(target));
    read_sp();
    chk("sp_call", v16, sp - 16'h0002);
    run(CSI_OP_RET, 5'd0, 8'h00);
    chk("ret_pc", 16'(pc_q), 16'(pc0 + 13'h0001));
    read_sp();
    chk("sp_ret", v16, sp);
    $display("test pointers and calls done");
    io_acc(1'b1, 6'h10, 8'h47);
    fire(8'h06);
    io_acc(1'b0, 6'h11, 8'h00);
    chk("flags_latched", 16'(rv), 16'h0006);
    run(CSI_OP_SEI, 5'd0, 8'h00);
    serve(1, 13'h0000);
    io_acc(1'b0, 6'h11, 8'h00);
    chk("flag_hw_clear", 16'(rv), 16'h0004);
    serve(2, 13'h0000);
    fire(8'h08);
    io_acc(1'b1, 6'h11, 8'h00);
    io_acc(1'b0, 6'h11, 8'h00);
    chk("flag_w0", 16'(rv), 16'h0008);
    io_acc(1'b1, 6'h11, 8'h08);
    io_acc(1'b0, 6'h11, 8'h00);
    chk("flag_w1", 16'(rv), 16'h0000);
    $display("test flags done");
    io_acc(1'b1, 6'h10, 8'h06);
    irq_level = 8'h40;
    fire(8'h01);
    irq_level = 8'h00;
    io_acc(1'b1, 6'h10, 8'h40);
    run(CSI_OP_NOP, 5'd0, 8'h00);
    run(CSI_OP_NOP, 5'd0, 8'h00);
    chk("level_gone", 16'(takes), 16'(tk));
    run(CSI_OP_SEI, 5'd0, 8'h00);
    irq_level = 8'h40;
    serve(6, 13'h0000);
    run(CSI_OP_CLI, 5'd0, 8'h00);
    io_acc(1'b1, 6'h10, 8'h03);
    run(CSI_OP_NOP, 5'd0, 8'h00);
    chk("cli_block", 16'(takes), 16'(tk));
    io_acc(1'b1, 6'h35, 8'h01);
    app_lk = 1'b1;
    run(CSI_OP_SEI, 5'd0, 8'h00);
    run(CSI_OP_NOP, 5'd0, 8'h00);
    chk("lock_block", 16'(takes), 16'(tk));
    run(CSI_OP_SEI, 5'd0, 8'h00);
    app_lk = 1'b0;
    serve(0, 13'h1C00);
    run(CSI_OP_NOP, 5'd0, 8'h00);
    sleep_req = 1'b1;
    fire(8'h02);
    wait_hi("wake_take", irq_taken_q);
    sleep_req = 1'b0;
    wait_hi("wake_entry", op_ready);
    chk("wake_vector", 16'(pc_q), 16'(vec(13'h1C00, 1)));
    $display("test interrupts done");
    end_sim();
  end
endmodule : cpu_stack_and_interrupt_entry_test
